// [rtl/dram_cmd_pkg.sv]
package dram_cmd_pkg;
   // link widths
   localparam int CA_W = 10;
   localparam int BANK_W = 3;
   localparam int NBANK = 8;
   localparam int COL_W = 10;
   localparam int ROW_W = 13;
   // rising-half encodings on cmd_addr_bus bits [3:0] / [2:0] / [1:0]
   localparam logic [3:0] ENC_PRE = 4'hB;
   localparam logic [3:0] ENC_MRW = 4'h0;
   localparam logic [2:0] ENC_NOP = 3'h7;
   localparam logic [2:0] ENC_DPD = 3'h3;
   localparam logic [2:0] ENC_SELF_REFRESH_STATE = 3'h4;
   localparam logic [2:0] ENC_WR = 3'h1;
   localparam logic [2:0] ENC_RD = 3'h5;
   localparam logic [1:0] ENC_ACT = 2'h2;
   // field positions on the link
   localparam int AB_BIT = 4;
   localparam int AP_BIT = 0;
   localparam int BANK_LSB = 7;
   // device states, gray along power-on, reset, idle, active, power-down
   typedef enum logic [3:0] {
      ST_POWER_ON = 4'h0,
      ST_RESETTING = 4'h1,
      ST_IDLE = 4'h3,
      ST_ACTIVE = 4'h2,
      ST_ACTIVE_PD = 4'h6,
      ST_IDLE_PD = 4'h7,
      ST_RESET_PD = 4'h5,
      ST_SELF_REFRESH = 4'h4,
      ST_DEEP_PD = 4'hC
   } dev_state_e;
   // decoded command kinds reported by the device
   localparam logic [2:0] K_NONE = 3'h0;
   localparam logic [2:0] K_ACT = 3'h1;
   localparam logic [2:0] K_RD = 3'h2;
   localparam logic [2:0] K_WR = 3'h3;
   localparam logic [2:0] K_PRE = 3'h4;
   localparam logic [2:0] K_MRW = 3'h5;
   // controller operation codes written to the command register
   localparam logic [3:0] OP_ACT = 4'h1;
   localparam logic [3:0] OP_RD = 4'h2;
   localparam logic [3:0] OP_WR = 4'h3;
   localparam logic [3:0] OP_PRE = 4'h4;
   localparam logic [3:0] OP_MRW = 4'h5;
   localparam logic [3:0] OP_PD = 4'h6;
   localparam logic [3:0] OP_SELF_REFRESH_STATE = 4'h7;
   localparam logic [3:0] OP_DPD = 4'h8;
   localparam logic [3:0] OP_EXIT = 4'h9;
   // controller register offsets and command field positions
   localparam logic [11:0] REG_CMD = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam int F_BANK = 4;
   localparam int F_FLAG = 7;
   localparam int F_ADDR = 8;
   // timing, figures in ns, counts at the 25 MHz clock (least times round up)
   localparam int CLK_MHZ = 25;
   localparam int PD_EXIT_NS = 8;
   localparam int SR_EXIT_NS = 140;
   localparam int INIT_WAIT_NS = 10000;
   localparam int MIN_TOGGLES = 2;
   localparam int PD_EXIT_CYC_RAW = (PD_EXIT_NS * CLK_MHZ + 999) / 1000;
   localparam int SR_EXIT_CYC_RAW = (SR_EXIT_NS * CLK_MHZ + 999) / 1000;
   localparam int PD_EXIT_CYC = PD_EXIT_CYC_RAW < MIN_TOGGLES ? MIN_TOGGLES : PD_EXIT_CYC_RAW;
   localparam int SR_EXIT_CYC = SR_EXIT_CYC_RAW < MIN_TOGGLES ? MIN_TOGGLES : SR_EXIT_CYC_RAW;
   localparam int INIT_WAIT_CYC = (INIT_WAIT_NS * CLK_MHZ + 999) / 1000;
endpackage

// [rtl/dram_link_if.sv]
`timescale 1ns/1ps
// command link between memory controller and dram device
interface dram_link_if;
   import dram_cmd_pkg::*;
   logic cs_n; // chip select, active low
   logic cke; // clock enable pin
   logic [CA_W-1:0] ca_rise; // cmd_addr_bus rising-edge half
   logic [CA_W-1:0] ca_fall; // cmd_addr_bus falling-edge half
   modport device (input cs_n, input cke, input ca_rise, input ca_fall);
   modport controller (output cs_n, output cke, output ca_rise, output ca_fall);
endinterface

// [rtl/dram_device.sv]
`timescale 1ns/1ps
// Overview of operation
// - commands from chip select, bits 0-3, cke
// - sample at rising edge, compare previous cke
// - one cycle: rising set, then falling set
// - bank-select bits choose the bank
// - auto-precharge flag closes bank after access
// - precharge encoding; all-bank flag ignores bank
// - lowest column bit is always zero
// - controller may float bus while deselected
// - controller may float pins in low power
// - self-refresh and deep exits need no clock
// - cke low twice: stay, ignore bus
// - exit active power-down to active
// - exit idle power-down to idle
// - resetting exit: idle if init wait done
// - deep power-down exit goes to power-on
// - only nops during power-down exit time
// - only nops during self-refresh exit time
// - self-refresh: outputs hi-z or terminated
// - cke high twice: ordinary command decode
// - controller avoids illegal state/cke combinations; this one may send deep power-down while active, leaving cke low
// - next state from prior state and command
// - nop: deselect or bits 0-2 high
module dram_device #(
   parameter int INIT_CYC = dram_cmd_pkg::INIT_WAIT_CYC
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   dram_link_if.device link,
   input wire logic odt_en_in,
   output dram_cmd_pkg::dev_state_e state_out,
   output logic cmd_valid_out,
   output logic [2:0] cmd_kind_out,
   output logic [dram_cmd_pkg::BANK_W-1:0] bank_out,
   output logic [dram_cmd_pkg::COL_W-1:0] column_out,
   output logic [dram_cmd_pkg::ROW_W-1:0] row_out,
   output logic auto_precharge_out,
   output logic all_bank_out,
   output logic [dram_cmd_pkg::NBANK-1:0] open_banks_out,
   output logic init_done_out,
   output logic wake_out,
   output logic dq_hiz_out,
   output logic dq_term_out
);
   import dram_cmd_pkg::*;

   dev_state_e state_r, state_nxt; // power state
   logic cke_prev_r; // cke at the previous rising edge
   logic [NBANK-1:0] mask_r, mask_nxt; // open rows per bank
   logic [2:0] pend_r; // command kind waiting for its falling half
   logic [CA_W-1:0] rise_r; // rising half of that command
   logic [CA_W-1:0] fall_r; // falling half captured at the negedge
   logic [31:0] init_cnt_r; // final_init_wait counter
   logic dq_hiz_r, dq_term_r; // output pad mode while self-refreshing
   logic valid_r; // one-cycle report strobe
   logic ap_r; // auto_precharge_flag of the reported access

   // decoded pin levels at this rising edge
   logic cs_n, cke, both_hi, fall_edge, rise_edge, both_lo;
   logic is_nop, is_pre, is_dpd, is_self_refresh_state, is_act, is_wr, is_rd, is_mrw;
   logic [BANK_W-1:0] rbank;
   logic [2:0] kind;

   assign cs_n = link.cs_n;
   assign cke = link.cke;
   // cke at edge n against edge n-1 picks the table in use
   assign both_hi = cke_prev_r & cke;
   assign fall_edge = cke_prev_r & ~cke;
   assign rise_edge = ~cke_prev_r & cke;
   assign both_lo = ~cke_prev_r & ~cke;
   // bus bits are only read when chip select is low, so a floated bus is harmless
   assign is_nop = cs_n | (link.ca_rise[2:0] == ENC_NOP);
   assign is_pre = ~cs_n & (link.ca_rise[3:0] == ENC_PRE);
   assign is_mrw = ~cs_n & (link.ca_rise[3:0] == ENC_MRW);
   assign is_dpd = ~cs_n & (link.ca_rise[2:0] == ENC_DPD);
   assign is_self_refresh_state = ~cs_n & (link.ca_rise[2:0] == ENC_SELF_REFRESH_STATE);
   assign is_act = ~cs_n & (link.ca_rise[1:0] == ENC_ACT);
   assign is_wr = ~cs_n & (link.ca_rise[2:0] == ENC_WR);
   assign is_rd = ~cs_n & (link.ca_rise[2:0] == ENC_RD);
   assign rbank = link.ca_rise[BANK_LSB +: BANK_W];

   // ordinary command kind, only meaningful with cke high twice
   always_comb begin
      kind = K_NONE;
      if (!both_hi || is_nop) begin
         kind = K_NONE; // nop or a power transition, nothing to report
      end else if (is_pre) begin
         kind = K_PRE;
      end else if (is_mrw) begin
         kind = K_MRW;
      end else if (is_act) begin
         kind = K_ACT;
      end else if (is_wr) begin
         kind = K_WR;
      end else if (is_rd) begin
         kind = K_RD;
      end
   end

   // open-bank bookkeeping: activate opens, precharge and auto-precharge close
   always_comb begin
      mask_nxt = mask_r;
      if (pend_r == K_RD || pend_r == K_WR) begin
         if (fall_r[AP_BIT]) begin
            mask_nxt[rise_r[BANK_LSB +: BANK_W]] = 1'b0;
         end
      end
      if (kind == K_ACT) begin
         mask_nxt[rbank] = 1'b1;
      end else if (kind == K_PRE) begin
         if (link.ca_rise[AB_BIT]) begin
            mask_nxt = '0; // bank bits are don't care here
         end else begin
            mask_nxt[rbank] = 1'b0;
         end
      end
   end

   // power-state transitions from the state before edge n and command n
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_POWER_ON: begin
            if (kind == K_MRW) begin
               state_nxt = ST_RESETTING;
            end
         end
         ST_RESETTING: begin
            if (fall_edge && cs_n) begin
               state_nxt = ST_RESET_PD;
            end else if (both_hi && init_done_out) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE, ST_ACTIVE: begin
            if (fall_edge) begin
               if (state_r == ST_ACTIVE && cs_n) begin
                  state_nxt = ST_ACTIVE_PD;
               end else if (cs_n) begin
                  state_nxt = ST_IDLE_PD;
               end else if (state_r == ST_IDLE && is_self_refresh_state) begin
                  state_nxt = ST_SELF_REFRESH;
               end else if (state_r == ST_IDLE && is_dpd) begin
                  state_nxt = ST_DEEP_PD;
               end
            end else if (both_hi) begin
               if (state_r == ST_IDLE && kind == K_MRW) begin
                  state_nxt = ST_RESETTING;
               end else begin
                  state_nxt = (|mask_nxt) ? ST_ACTIVE : ST_IDLE;
               end
            end
         end
         ST_ACTIVE_PD: begin
            if (rise_edge && cs_n) begin
               state_nxt = ST_ACTIVE;
            end
         end
         ST_IDLE_PD: begin
            if (rise_edge && cs_n) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RESET_PD: begin
            if (rise_edge && cs_n) begin
               state_nxt = init_done_out ? ST_IDLE : ST_RESETTING;
            end
         end
         ST_SELF_REFRESH: begin
            if (rise_edge && cs_n) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_DEEP_PD: begin
            if (rise_edge && cs_n) begin
               state_nxt = ST_POWER_ON;
            end
         end
         default: begin
            state_nxt = ST_POWER_ON;
         end
      endcase
      // cke low at both edges: nothing moves, bus and select ignored
      if (both_lo) begin
         state_nxt = state_r;
      end
   end

   // state, cke history and open banks
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_r <= ST_POWER_ON;
         cke_prev_r <= 1'b0;
         mask_r <= '0;
      end else if (ce_in) begin
         state_r <= state_nxt;
         cke_prev_r <= cke;
         mask_r <= (state_nxt == ST_POWER_ON) ? '0 : mask_nxt;
      end
   end

   // rising half held until its falling half has been captured
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pend_r <= K_NONE;
         rise_r <= '0;
      end else if (ce_in) begin
         pend_r <= kind;
         rise_r <= link.ca_rise;
      end
   end

   // falling half of the cycle's command
   always_ff @(negedge clock_in) begin
      if (rst_in) begin
         fall_r <= '0;
      end else if (ce_in) begin
         fall_r <= link.ca_fall;
      end
   end

   // field report, one cycle after the command's rising edge
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         valid_r <= 1'b0;
         cmd_kind_out <= K_NONE;
         bank_out <= '0;
         column_out <= '0;
         row_out <= '0;
         ap_r <= 1'b0;
         all_bank_out <= 1'b0;
      end else if (ce_in) begin
         valid_r <= (pend_r != K_NONE);
         cmd_kind_out <= pend_r;
         bank_out <= rise_r[BANK_LSB +: BANK_W];
         // column bit zero is never sent
         column_out <= {fall_r[7:1], rise_r[6:5], 1'b0};
         row_out <= {rise_r[6:2], fall_r[7:0]};
         ap_r <= (pend_r == K_RD || pend_r == K_WR) & fall_r[AP_BIT];
         all_bank_out <= (pend_r == K_PRE) & rise_r[AB_BIT];
      end
   end

   // final_init_wait runs while resetting, also through resetting power-down
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         init_cnt_r <= '0;
      end else if (ce_in) begin
         if (state_r == ST_POWER_ON) begin
            init_cnt_r <= '0;
         end else if (init_cnt_r < INIT_CYC) begin
            init_cnt_r <= init_cnt_r + 32'h1;
         end
      end
   end

   // pad mode follows the termination setting on every cycle in self-refresh
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         dq_hiz_r <= 1'b0;
         dq_term_r <= 1'b0;
      end else if (ce_in) begin
         dq_hiz_r <= (state_nxt == ST_SELF_REFRESH) & ~odt_en_in;
         dq_term_r <= (state_nxt == ST_SELF_REFRESH) & odt_en_in;
      end
   end

   // wake is pure logic on the pin so it works with the clock stopped
   assign wake_out = ((state_r == ST_SELF_REFRESH) || (state_r == ST_DEEP_PD)) & cke;
   assign init_done_out = (init_cnt_r >= INIT_CYC);
   assign state_out = state_r;
   assign cmd_valid_out = valid_r;
   assign auto_precharge_out = ap_r;
   assign open_banks_out = mask_r;
   assign dq_hiz_out = dq_hiz_r;
   assign dq_term_out = dq_term_r;
endmodule

// [rtl/dram_controller.sv]
`timescale 1ns/1ps
// memory-controller end: apb command register drives the link
module dram_controller #(
   parameter int PD_CYC = dram_cmd_pkg::PD_EXIT_CYC,
   parameter int SR_CYC = dram_cmd_pkg::SR_EXIT_CYC
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   dram_link_if.controller link
);
   import dram_cmd_pkg::*;

   typedef enum logic [1:0] {
      LP_NONE = 2'h0,
      LP_PD = 2'h1,
      LP_SELF_REFRESH_STATE = 2'h3,
      LP_DPD = 2'h2
   } lp_e;

   lp_e lp_r; // low-power mode the device was put in
   logic cs_n_r, cke_r; // pin registers
   logic [CA_W-1:0] rise_r, fall_r; // bus halves
   logic [7:0] wait_r; // exit-time nop countdown
   logic rej_r; // last command refused as illegal
   logic need_init_r; // deep power-down left, reset sequence required
   logic wr_cmd, legal;
   logic [3:0] op;
   logic [BANK_W-1:0] bk;
   logic fl;
   logic [12:0] ad;

   assign wr_cmd = psel_in & penable_in & pwrite_in & (paddr_in == REG_CMD);
   assign op = pwdata_in[3:0];
   assign bk = pwdata_in[F_BANK +: BANK_W];
   assign fl = pwdata_in[F_FLAG];
   assign ad = pwdata_in[F_ADDR +: 13];
   // only exits in low power, no exit outside it, none while waiting
   assign legal = (wait_r == 8'h0) && ((lp_r != LP_NONE) == (op == OP_EXIT));

   // pin drive; cs_n returns high after every one-cycle command
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cs_n_r <= 1'b1;
         cke_r <= 1'b1;
         rise_r <= '0;
         fall_r <= '0;
         lp_r <= LP_NONE;
      end else if (ce_in) begin
         cs_n_r <= 1'b1; // nop between commands
         if (wr_cmd && legal) begin
            fall_r <= '0;
            case (op)
               OP_ACT: begin
                  cs_n_r <= 1'b0;
                  rise_r <= {bk, ad[12:8], ENC_ACT};
                  fall_r <= {2'h0, ad[7:0]};
               end
               OP_RD, OP_WR: begin
                  cs_n_r <= 1'b0;
                  rise_r <= {bk, ad[2:1], 2'h0, (op == OP_RD) ? ENC_RD : ENC_WR};
                  fall_r <= {2'h0, ad[9:3], fl};
               end
               OP_PRE: begin
                  cs_n_r <= 1'b0;
                  rise_r <= {bk, 2'h0, fl, ENC_PRE};
               end
               OP_MRW: begin
                  cs_n_r <= 1'b0;
                  rise_r <= {6'h3F, ENC_MRW};
               end
               OP_PD: begin
                  cke_r <= 1'b0; // cke fall, deselected
                  lp_r <= LP_PD;
               end
               OP_SELF_REFRESH_STATE: begin
                  cs_n_r <= 1'b0;
                  cke_r <= 1'b0;
                  rise_r <= {7'h0, ENC_SELF_REFRESH_STATE};
                  lp_r <= LP_SELF_REFRESH_STATE;
               end
               OP_DPD: begin
                  cs_n_r <= 1'b0;
                  cke_r <= 1'b0;
                  rise_r <= {7'h0, ENC_DPD};
                  lp_r <= LP_DPD;
               end
               OP_EXIT: begin
                  cke_r <= 1'b1; // rise with cs_n high
                  lp_r <= LP_NONE;
               end
               default: begin
                  cs_n_r <= 1'b1;
               end
            endcase
         end
      end
   end

   // pins stay driven in low power, which is always allowed
   assign link.cs_n = cs_n_r;
   assign link.cke = cke_r;
   assign link.ca_rise = rise_r;
   assign link.ca_fall = fall_r;

   // nop-only window after any exit
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         wait_r <= 8'h0;
      end else if (ce_in) begin
         if (wr_cmd && legal && op == OP_EXIT) begin
            wait_r <= (lp_r == LP_SELF_REFRESH_STATE) ? 8'(SR_CYC) : 8'(PD_CYC);
         end else if (wait_r != 8'h0) begin
            wait_r <= wait_r - 8'h1;
         end
      end
   end

   // status flags
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rej_r <= 1'b0;
         need_init_r <= 1'b0;
      end else if (ce_in) begin
         if (wr_cmd) begin
            rej_r <= ~legal;
         end
         if (wr_cmd && legal && op == OP_EXIT && lp_r == LP_DPD) begin
            need_init_r <= 1'b1; // full reset sequence owed
         end else if (wr_cmd && legal && op == OP_MRW) begin
            need_init_r <= 1'b0;
         end
      end
   end

   // apb read data, zero for unmapped offsets
   always_comb begin
      prdata_out = 32'h0;
      if (paddr_in == REG_STATUS) begin
         prdata_out = {26'h0, need_init_r, rej_r, lp_r, cke_r, (wait_r != 8'h0)};
      end
   end
   assign pready_out = 1'b1;
   assign pslverr_out = 1'b0;
endmodule

// [test/dram_link_sva.sv]
`timescale 1ns/1ps
// link and power-state checks between the two ends
module dram_link_sva (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic cs_n,
   input wire logic cke,
   input wire logic odt_en_in,
   input wire dram_cmd_pkg::dev_state_e state_out,
   input wire logic cmd_valid_out,
   input wire logic [dram_cmd_pkg::COL_W-1:0] column_out,
   input wire logic wake_out,
   input wire logic dq_hiz_out,
   input wire logic dq_term_out
);
   import dram_cmd_pkg::*;
   default clocking cb @(posedge clock_in); endclocking
   // a frozen device holds state, so its cycles are not judged
   default disable iff (rst_in || !ce_in);
   // clock-enable edges with the chip deselected
   sequence s_fall;
      $past(cke) && !cke && cs_n;
   endsequence
   sequence s_rise;
      !$past(cke) && cke && cs_n;
   endsequence
   property p_col0;
      cmd_valid_out |-> column_out[0] == 1'b0;
   endproperty
   a_col0: assert property (p_col0) else $error("column bit 0 set");
   property p_hold;
      !$past(cke) && !cke |=> state_out == $past(state_out);
   endproperty
   a_hold: assert property (p_hold) else $error("low power state moved");
   property p_act_exit;
      s_rise ##0 state_out == ST_ACTIVE_PD |=> state_out == ST_ACTIVE;
   endproperty
   a_act_exit: assert property (p_act_exit) else $error("active exit wrong");
   property p_idle_exit;
      s_rise ##0 state_out == ST_IDLE_PD |=> state_out == ST_IDLE;
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong");
   property p_deep_exit;
      s_rise ##0 state_out == ST_DEEP_PD |=> state_out == ST_POWER_ON;
   endproperty
   a_deep_exit: assert property (p_deep_exit) else $error("deep exit wrong");
   // wake shows at once and the exit lands at the next edge
   property p_wake;
      cke && cs_n && (state_out == ST_SELF_REFRESH || state_out == ST_DEEP_PD)
         |-> wake_out ##1 (state_out == ST_IDLE || state_out == ST_POWER_ON);
   endproperty
   a_wake: assert property (p_wake) else $error("wake not seen");
   property p_pd_entry;
      s_fall ##0 state_out == ST_IDLE |=> state_out == ST_IDLE_PD;
   endproperty
   a_pd_entry: assert property (p_pd_entry) else $error("idle pd entry wrong");
   property p_deep_src;
      state_out == ST_DEEP_PD && $past(state_out) != ST_DEEP_PD |-> $past(state_out) == ST_IDLE;
   endproperty
   a_deep_src: assert property (p_deep_src) else $error("deep entry not from idle");
   property p_dq;
      state_out == ST_SELF_REFRESH && $past(state_out) == ST_SELF_REFRESH && $stable(odt_en_in)
         |-> dq_term_out == odt_en_in && dq_hiz_out == !odt_en_in;
   endproperty
   a_dq: assert property (p_dq) else $error("dq level wrong");
   property p_nop_idle;
      cke && $past(cke) && cs_n && state_out == ST_IDLE |=> state_out == ST_IDLE;
   endproperty
   a_nop_idle: assert property (p_nop_idle) else $error("nop changed state");
   property p_pd_quiet;
      s_rise ##0 state_out == ST_IDLE_PD |-> cs_n [*2];
   endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("command in pd exit");
   property p_sr_quiet;
      s_rise ##0 state_out == ST_SELF_REFRESH |-> cs_n [*4];
   endproperty
   a_sr_quiet: assert property (p_sr_quiet) else $error("command in self_refresh_state exit");
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
// controller and device joined by the link, driven over apb
module testbench;
   import dram_cmd_pkg::*;
   logic clock_in = 0, rst_in = 1, ce_in = 1, odt_en_in = 0;
   logic psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, q;
   logic pready_out, pslverr_out, cmd_valid_out, auto_precharge_out, all_bank_out;
   logic init_done_out, wake_out, dq_hiz_out, dq_term_out;
   dev_state_e state_out;
   logic [2:0] cmd_kind_out, bank_out, k_r, b_r;
   logic [COL_W-1:0] column_out, c_r;
   logic [ROW_W-1:0] row_out, r_r;
   logic [NBANK-1:0] open_banks_out;
   logic ap_r, ab_r;
   int fails = 0, n_checks = 0, cyc = 0;
   always #20 clock_in = ~clock_in;
   dram_link_if dram_link_if_i ();
   dram_controller dram_controller_i (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .link(dram_link_if_i));
   // short init wait keeps the run brief, yet outlasts the reset power-down entry
   dram_device #(.INIT_CYC(12)) dram_device_i (.clock_in(clock_in), .rst_in(rst_in),
      .ce_in(ce_in), .link(dram_link_if_i), .odt_en_in(odt_en_in), .state_out(state_out),
      .cmd_valid_out(cmd_valid_out), .cmd_kind_out(cmd_kind_out), .bank_out(bank_out),
      .column_out(column_out), .row_out(row_out), .auto_precharge_out(auto_precharge_out),
      .all_bank_out(all_bank_out), .open_banks_out(open_banks_out),
      .init_done_out(init_done_out), .wake_out(wake_out), .dq_hiz_out(dq_hiz_out),
      .dq_term_out(dq_term_out));
   dram_link_sva dram_link_sva_i (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
      .cs_n(dram_link_if_i.cs_n), .cke(dram_link_if_i.cke), .odt_en_in(odt_en_in),
      .state_out(state_out), .cmd_valid_out(cmd_valid_out), .column_out(column_out),
      .wake_out(wake_out), .dq_hiz_out(dq_hiz_out), .dq_term_out(dq_term_out));
   // the report pulse lasts one cycle, so keep its fields
   always @(posedge clock_in) begin
      if (cmd_valid_out === 1'b1) begin
         k_r <= cmd_kind_out;
         b_r <= bank_out;
         c_r <= column_out;
         r_r <= row_out;
         ap_r <= auto_precharge_out;
         ab_r <= all_bank_out;
      end
   end
   // hang guard, well above the expected few hundred cycles
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      do @(posedge clock_in); while (pready_out !== 1'b1);
      q = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      // one idle edge, so a following call never reassigns psel in this step
      @(posedge clock_in);
   endtask
   // waits out the exit busy time, then issues one command
   task automatic cmd(input logic [3:0] op, input logic [2:0] bk, input logic fl,
                      input logic [12:0] ad);
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 100);
      if (n >= 100) fails++;
      apb(1'b1, REG_CMD, {11'h0, ad, fl, bk, op});
      repeat (4) @(posedge clock_in);
   endtask
   initial begin
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      `CHK("state", ST_POWER_ON, state_out)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("unmapped", 32'h0, q)
      cmd(OP_MRW, 3'h0, 1'b0, 13'h0);
      cmd(OP_PD, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_RESET_PD, state_out)
      repeat (10) @(posedge clock_in);
      cmd(OP_EXIT, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_IDLE, state_out)
      `CHK("init", 1'b1, init_done_out)
      cmd(OP_ACT, 3'h3, 1'b0, 13'h1ABC);
      `CHK("kind", K_ACT, k_r)
      `CHK("bank", 3'h3, b_r)
      `CHK("row", 13'h1ABC, r_r)
      `CHK("open", 8'h08, open_banks_out)
      cmd(OP_RD, 3'h3, 1'b1, 13'h2A7);
      `CHK("kind", K_RD, k_r)
      `CHK("column", 10'h2A6, c_r)
      `CHK("ap", 1'b1, ap_r)
      `CHK("open", 8'h00, open_banks_out)
      cmd(OP_ACT, 3'h5, 1'b0, 13'h0011);
      cmd(OP_ACT, 3'h1, 1'b0, 13'h0022);
      cmd(OP_WR, 3'h1, 1'b0, 13'h0155);
      `CHK("kind", K_WR, k_r)
      `CHK("ap", 1'b0, ap_r)
      `CHK("open", 8'h22, open_banks_out)
      cmd(OP_DPD, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_ACTIVE, state_out)
      // the refused entry left cke low, so lift it again before power-down
      cmd(OP_EXIT, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_ACTIVE, state_out)
      cmd(OP_PD, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_ACTIVE_PD, state_out)
      repeat (6) @(posedge clock_in);
      `CHK("state", ST_ACTIVE_PD, state_out)
      // a command other than exit in low power is refused by the controller
      cmd(OP_ACT, 3'h4, 1'b0, 13'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("rej", 1'b1, q[4])
      `CHK("state", ST_ACTIVE_PD, state_out)
      cmd(OP_EXIT, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_ACTIVE, state_out)
      cmd(OP_PRE, 3'h5, 1'b0, 13'h0);
      `CHK("ab", 1'b0, ab_r)
      `CHK("open", 8'h02, open_banks_out)
      cmd(OP_PRE, 3'h2, 1'b1, 13'h0);
      `CHK("kind", K_PRE, k_r)
      `CHK("ab", 1'b1, ab_r)
      `CHK("state", ST_IDLE, state_out)
      cmd(OP_PD, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_IDLE_PD, state_out)
      cmd(OP_EXIT, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_IDLE, state_out)
      // with the clock enable low both ends ignore a power-down order
      ce_in <= 1'b0;
      cmd(OP_PD, 3'h0, 1'b0, 13'h0);
      `CHK("frozen", ST_IDLE, state_out)
      ce_in <= 1'b1;
      // both termination settings during self-refresh
      for (int i = 0; i < 2; i++) begin
         odt_en_in <= i[0];
         cmd(OP_SELF_REFRESH_STATE, 3'h0, 1'b0, 13'h0);
         `CHK("state", ST_SELF_REFRESH, state_out)
         `CHK("hiz", !i[0], dq_hiz_out)
         `CHK("term", i[0], dq_term_out)
         cmd(OP_EXIT, 3'h0, 1'b0, 13'h0);
         `CHK("state", ST_IDLE, state_out)
      end
      cmd(OP_DPD, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_DEEP_PD, state_out)
      cmd(OP_EXIT, 3'h0, 1'b0, 13'h0);
      `CHK("state", ST_POWER_ON, state_out)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("need_init", 1'b1, q[5])
      summarize();
   end
endmodule
